// ===== rtl/hfq_cfg.svh
// Purpose: offsets, field positions, reset values of the frame queue control
// Assumes: byte offsets as seen on the register port
// Notes: definitions only
`ifndef HFQ_CFG_SVH
`define HFQ_CFG_SVH

`define HFQ_ADDR_W 9
`define HFQ_DATA_W 16
`define HFQ_PTR_W 11

// register offsets
`define HFQ_OFF_TXCMD 9'h180
`define HFQ_OFF_RXQCMD 9'h182
`define HFQ_OFF_TXPTR 9'h184
`define HFQ_OFF_IRQSTAT 9'h1a0
`define HFQ_OFF_IRQMASK 9'h1a2

// receive queue command fields
`define HFQ_RXQ_BYTE_STAT 11
`define HFQ_RXQ_FRAME_STAT 10
`define HFQ_RXQ_BYTE_EN 6
`define HFQ_RXQ_FRAME_EN 5
`define HFQ_RXQ_AUTODEQ 4
`define HFQ_RXQ_DMA 3
`define HFQ_RXQ_RELEASE 0

// transmit pointer and command fields
`define HFQ_TXP_AUTOINC 14
`define HFQ_TXCMD_ENQ 0
`define HFQ_TXP_RESET 11'h000

// access sizes on the host data port
`define HFQ_SIZE_BYTE 2'h0
`define HFQ_SIZE_WORD 2'h1
`define HFQ_SIZE_DWORD 2'h2

// interrupt status bits
`define HFQ_IRQ_W 4
`define HFQ_IRQ_THRESH 0
`define HFQ_IRQ_DEQ 1
`define HFQ_IRQ_REL 2
`define HFQ_IRQ_ENQ 3

`endif

// ===== rtl/hfq_pkg.sv
// Purpose: types of the frame queue control
// Assumes: constants live in hfq_cfg.svh
// Notes: one-hot state codes
package hfq_pkg;

    typedef enum logic [1:0] {
        HFQ_REL_IDLE = 2'h1,
        HFQ_REL_BUSY = 2'h2
    } hfq_rel_state_type;

endpackage

// ===== rtl/hfq_access_ctrl.sv
// Purpose: host access control of the receive and transmit frame queues
// Assumes: one clock; host bus pins are asynchronous and synchronised here
// Notes: queue datapath, threshold registers and timer are outside
//
// Local design decision: strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "hfq_cfg.svh"

// Overview of operation
// RULE1 - with the byte threshold enable set, a byte count above the byte threshold raises the receive interrupt.
// RULE2 - with the frame threshold enable set, a frame count above the frame threshold raises the receive interrupt.
// RULE3 - with auto dequeue set, the read pointer moves to the next frame once the current one is fully read.
// RULE4 - while the access bit is set, host strobes with the command pin low reach the receive or transmit buffer.
// RULE5 - during a buffer access window only the receive queue command register can be reached.
// RULE6 - the host clears the access bit when done before touching any other register.
// RULE7 - writing one to the release bit frees the current error frame and the bit clears when freed.
// RULE8 - the host polls the release bit until clear before handling another frame.
// RULE9 - with auto increment set, each host buffer write advances the transmit pointer.
// RULE10 - the pointer steps by one, two or four for byte, word or double word accesses.
// RULE11 - with auto increment clear, the pointer changes only when software writes it; the code also reloads it from txNextFree on txEnqueueDone.
// RULE12 - the pointer is eleven bits, resets to zero and reloads with the next free slot after an enqueue.
// RULE13 - the enqueue command queues one frame and clears itself once that frame has gone.
// RULE14 - thresholds come in as inputs and are compared with live occupancy every cycle.
module hfq_access_ctrl #(
    parameter int BYTE_CNT_W = 16,
    parameter int FRAME_CNT_W = 8
) (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // register port
    input wire logic [`HFQ_ADDR_W-1:0] regAddr,
    input wire logic [`HFQ_DATA_W-1:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [`HFQ_DATA_W-1:0] regRdData,
    // host data pins
    input wire logic chipSelect_n,
    input wire logic readStrobe_n,
    input wire logic writeStrobe_n,
    input wire logic cmdPin,
    input wire logic [1:0] hostAccessSize,
    // receive queue side
    input wire logic [BYTE_CNT_W-1:0] rxByteCount,
    input wire logic [FRAME_CNT_W-1:0] rxFrameCount,
    input wire logic [BYTE_CNT_W-1:0] rxByteThresholdValue,
    input wire logic [FRAME_CNT_W-1:0] rxFrameThresholdValue,
    input wire logic rxFrameReadDone,
    input wire logic rxReleaseDone,
    output logic rxThresholdIrq,
    output logic rxDequeue,
    output logic rxReleaseReq,
    output logic rxBufRead,
    // transmit queue side
    input wire logic txEnqueueDone,
    input wire logic [`HFQ_PTR_W-1:0] txNextFree,
    output logic txEnqueueReq,
    output logic txBufWrite,
    output logic [`HFQ_PTR_W-1:0] txFramePointer,
    output logic [1:0] bufAccessSize,
    // interrupt
    output logic irq
);

    // synchronisers for host pins: {size, cmd, wr, rd, cs}
    logic [5:0] pinMeta_q;
    logic [5:0] pinSync_q;
    logic [5:0] pinIn;
    logic csSync_n;
    logic rdSync_n;
    logic wrSync_n;
    logic cmdSync;
    logic [1:0] sizeSync;

    // control state
    logic byteThrEn_q;
    logic frameThrEn_q;
    logic autoDeqEn_q;
    logic dmaActive_q;
    logic txAutoInc_q;
    logic [`HFQ_PTR_W-1:0] txPtr_q;
    logic [`HFQ_PTR_W-1:0] txPtr_d;
    logic enqReq_q;
    hfq_pkg::hfq_rel_state_type relState_q;
    hfq_pkg::hfq_rel_state_type relState_d;
    logic rdAccPrev_q;
    logic wrAccPrev_q;
    logic rxBufRead_q;
    logic txBufWrite_q;
    logic rxDequeue_q;
    logic thrHit_q;
    logic [`HFQ_IRQ_W-1:0] irqStat_q;
    logic [`HFQ_IRQ_W-1:0] irqStat_d;
    logic [`HFQ_IRQ_W-1:0] irqMask_q;
    logic [`HFQ_DATA_W-1:0] rdData_q;
    logic [`HFQ_DATA_W-1:0] rdData_d;

    // decode
    wire selTxCmd = (regAddr == `HFQ_OFF_TXCMD);
    wire selRxqCmd = (regAddr == `HFQ_OFF_RXQCMD);
    wire selTxPtr = (regAddr == `HFQ_OFF_TXPTR);
    wire selIrqStat = (regAddr == `HFQ_OFF_IRQSTAT);
    wire selIrqMask = (regAddr == `HFQ_OFF_IRQMASK);
    // only the receive queue command stays open in a window
    wire regOpen = ~dmaActive_q | selRxqCmd; // see RULE5
    wire wrEn = regWrStb & regOpen; // see RULE5
    wire rdEn = regRdStb & regOpen; // see RULE5
    wire wrTxCmd = wrEn & selTxCmd;
    wire wrRxqCmd = wrEn & selRxqCmd;
    wire wrTxPtr = wrEn & selTxPtr;
    wire wrIrqStat = wrEn & selIrqStat;
    wire wrIrqMask = wrEn & selIrqMask;

    // threshold comparison against live occupancy
    wire byteHit = rxByteCount > rxByteThresholdValue; // see RULE14
    wire frameHit = rxFrameCount > rxFrameThresholdValue; // see RULE14
    wire thrNow = (byteThrEn_q & byteHit) // see RULE1
        | (frameThrEn_q & frameHit); // see RULE2
    wire thrRise = thrNow & ~thrHit_q;

    // host buffer accesses inside the window
    assign pinIn = {hostAccessSize, cmdPin, writeStrobe_n, readStrobe_n,
        chipSelect_n};
    assign csSync_n = pinSync_q[0];
    assign rdSync_n = pinSync_q[1];
    assign wrSync_n = pinSync_q[2];
    assign cmdSync = pinSync_q[3];
    assign sizeSync = pinSync_q[5:4];
    wire bufSel = dmaActive_q & ~csSync_n & ~cmdSync; // see RULE4
    wire rdAccNow = bufSel & ~rdSync_n;
    wire wrAccNow = bufSel & ~wrSync_n;
    wire rdAccStart = rdAccNow & ~rdAccPrev_q; // see RULE4
    wire wrAccStart = wrAccNow & ~wrAccPrev_q; // see RULE4

    // pointer step by access size
    wire [`HFQ_PTR_W-1:0] txStep =
        (sizeSync == `HFQ_SIZE_DWORD) ? 11'h004 :
        (sizeSync == `HFQ_SIZE_WORD) ? 11'h002 : 11'h001; // see RULE10

    // dequeue request once a whole frame has been read
    wire deqNow = autoDeqEn_q & rxFrameReadDone; // see RULE3

    // release engine
    wire relStart = wrRxqCmd & regWrData[`HFQ_RXQ_RELEASE];
    wire relDoneNow = (relState_q == hfq_pkg::HFQ_REL_BUSY) & rxReleaseDone;

    // pointer next value
    always_comb
    begin
        txPtr_d = txPtr_q; // see RULE11
        if (txEnqueueDone)
        begin
            txPtr_d = txNextFree; // see RULE12
        end
        else if (wrTxPtr)
        begin
            txPtr_d = regWrData[`HFQ_PTR_W-1:0]; // see RULE11
        end
        else if (wrAccStart & txAutoInc_q)
        begin
            txPtr_d = txPtr_q + txStep; // see RULE9
        end
    end

    // release state machine
    always_comb
    begin
        relState_d = relState_q;
        case (relState_q)
            hfq_pkg::HFQ_REL_IDLE:
            begin
                if (relStart)
                begin
                    relState_d = hfq_pkg::HFQ_REL_BUSY; // see RULE7
                end
            end
            hfq_pkg::HFQ_REL_BUSY:
            begin
                if (rxReleaseDone & ~relStart)
                begin
                    relState_d = hfq_pkg::HFQ_REL_IDLE; // see RULE7
                end
            end
            default:
            begin
                relState_d = hfq_pkg::HFQ_REL_IDLE;
            end
        endcase
    end

    // sticky status: set wins over a write-one clear
    always_comb
    begin
        irqStat_d = irqStat_q;
        if (wrIrqStat)
        begin
            irqStat_d = irqStat_q & ~regWrData[`HFQ_IRQ_W-1:0];
        end
        if (thrRise)
        begin
            irqStat_d[`HFQ_IRQ_THRESH] = 1'b1; // see RULE1
        end
        if (deqNow)
        begin
            irqStat_d[`HFQ_IRQ_DEQ] = 1'b1;
        end
        if (relDoneNow)
        begin
            irqStat_d[`HFQ_IRQ_REL] = 1'b1;
        end
        if (enqReq_q & txEnqueueDone)
        begin
            irqStat_d[`HFQ_IRQ_ENQ] = 1'b1;
        end
    end

    // read mux
    always_comb
    begin
        rdData_d = '0;
        if (rdEn & selRxqCmd)
        begin
            rdData_d[`HFQ_RXQ_BYTE_STAT] = byteHit;
            rdData_d[`HFQ_RXQ_FRAME_STAT] = frameHit;
            rdData_d[`HFQ_RXQ_BYTE_EN] = byteThrEn_q;
            rdData_d[`HFQ_RXQ_FRAME_EN] = frameThrEn_q;
            rdData_d[`HFQ_RXQ_AUTODEQ] = autoDeqEn_q;
            rdData_d[`HFQ_RXQ_DMA] = dmaActive_q;
            rdData_d[`HFQ_RXQ_RELEASE] =
                (relState_q == hfq_pkg::HFQ_REL_BUSY); // see RULE8
        end
        else if (rdEn & selTxPtr)
        begin
            rdData_d[`HFQ_TXP_AUTOINC] = txAutoInc_q;
            rdData_d[`HFQ_PTR_W-1:0] = txPtr_q;
        end
        else if (rdEn & selTxCmd)
        begin
            rdData_d[`HFQ_TXCMD_ENQ] = enqReq_q;
        end
        else if (rdEn & selIrqStat)
        begin
            rdData_d[`HFQ_IRQ_W-1:0] = irqStat_q;
        end
        else if (rdEn & selIrqMask)
        begin
            rdData_d[`HFQ_IRQ_W-1:0] = irqMask_q;
        end
    end

    // pin synchronisers
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            pinMeta_q <= 6'h0f;
            pinSync_q <= 6'h0f;
        end
        else if (clkEn)
        begin
            pinMeta_q <= pinIn;
            pinSync_q <= pinMeta_q;
        end
    end

    // control register fields
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            byteThrEn_q <= 1'b0;
            frameThrEn_q <= 1'b0;
            autoDeqEn_q <= 1'b0;
            dmaActive_q <= 1'b0;
            txAutoInc_q <= 1'b0;
            irqMask_q <= '0;
        end
        else if (clkEn)
        begin
            if (wrRxqCmd)
            begin
                byteThrEn_q <= regWrData[`HFQ_RXQ_BYTE_EN];
                frameThrEn_q <= regWrData[`HFQ_RXQ_FRAME_EN];
                autoDeqEn_q <= regWrData[`HFQ_RXQ_AUTODEQ];
                dmaActive_q <= regWrData[`HFQ_RXQ_DMA]; // see RULE6
            end
            if (wrTxPtr)
            begin
                txAutoInc_q <= regWrData[`HFQ_TXP_AUTOINC];
            end
            if (wrIrqMask)
            begin
                irqMask_q <= regWrData[`HFQ_IRQ_W-1:0];
            end
        end
    end

    // pointer, enqueue command, release state
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            txPtr_q <= `HFQ_TXP_RESET; // see RULE12
            enqReq_q <= 1'b0;
            relState_q <= hfq_pkg::HFQ_REL_IDLE;
        end
        else if (clkEn)
        begin
            txPtr_q <= txPtr_d;
            relState_q <= relState_d;
            if (wrTxCmd & regWrData[`HFQ_TXCMD_ENQ])
            begin
                enqReq_q <= 1'b1; // see RULE13
            end
            else if (txEnqueueDone)
            begin
                enqReq_q <= 1'b0; // see RULE13
            end
        end
    end

    // access edges, pulses, status, read data
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            rdAccPrev_q <= 1'b0;
            wrAccPrev_q <= 1'b0;
            rxBufRead_q <= 1'b0;
            txBufWrite_q <= 1'b0;
            rxDequeue_q <= 1'b0;
            thrHit_q <= 1'b0;
            irqStat_q <= '0;
            rdData_q <= '0;
        end
        else if (clkEn)
        begin
            rdAccPrev_q <= rdAccNow;
            wrAccPrev_q <= wrAccNow;
            rxBufRead_q <= rdAccStart; // see RULE4
            txBufWrite_q <= wrAccStart; // see RULE4
            rxDequeue_q <= deqNow; // see RULE3
            thrHit_q <= thrNow;
            irqStat_q <= irqStat_d;
            rdData_q <= rdData_d;
        end
    end

    // outputs
    assign regRdData = rdData_q;
    assign rxThresholdIrq = thrHit_q; // see RULE1
    assign rxDequeue = rxDequeue_q & clkEn;
    assign rxReleaseReq = (relState_q == hfq_pkg::HFQ_REL_BUSY); // see RULE7
    assign rxBufRead = rxBufRead_q & clkEn;
    assign txEnqueueReq = enqReq_q;
    assign txBufWrite = txBufWrite_q & clkEn;
    assign txFramePointer = txPtr_q;
    assign bufAccessSize = sizeSync;
    assign irq = |(irqStat_q & irqMask_q);

endmodule
`default_nettype wire

// ===== tb/hfq_access_ctrl_asserts.sv
// Purpose: port checks of the frame queue access control
// Assumes: host strobes held low for several cycles
// Notes: bound to every instance of the block
`timescale 1ns/10ps
`default_nettype none
`include "hfq_cfg.svh"
module hfq_access_ctrl_asserts #(
    parameter int BYTE_CNT_W = 16,
    parameter int FRAME_CNT_W = 8
) (
    // clock, reset, register port
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic regWrStb,
    // host pins
    input wire logic chipSelect_n,
    input wire logic writeStrobe_n,
    // receive side
    input wire logic [BYTE_CNT_W-1:0] rxByteCount,
    input wire logic [FRAME_CNT_W-1:0] rxFrameCount,
    input wire logic [BYTE_CNT_W-1:0] rxByteThresholdValue,
    input wire logic [FRAME_CNT_W-1:0] rxFrameThresholdValue,
    input wire logic rxFrameReadDone,
    input wire logic rxReleaseDone,
    input wire logic rxThresholdIrq,
    input wire logic rxDequeue,
    input wire logic rxReleaseReq,
    // transmit side
    input wire logic txEnqueueDone,
    input wire logic [`HFQ_PTR_W-1:0] txNextFree,
    input wire logic txEnqueueReq,
    input wire logic txBufWrite,
    input wire logic [`HFQ_PTR_W-1:0] txFramePointer,
    input wire logic [1:0] bufAccessSize
);
    wire logic [`HFQ_PTR_W-1:0] stepW;
    assign stepW = (bufAccessSize == `HFQ_SIZE_WORD) ? 11'h2 :
        (bufAccessSize == `HFQ_SIZE_DWORD) ? 11'h4 : 11'h1;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    AST_THRESH: assert property (rxThresholdIrq |->
        $past(rxByteCount > rxByteThresholdValue ||
        rxFrameCount > rxFrameThresholdValue)) else $error("stray threshold");
    AST_DEQUEUE: assert property (
        rxDequeue |-> $past(rxFrameReadDone)) else $error("stray dequeue");
    AST_BUF_WRITE: assert property (txBufWrite |->
        $past(!chipSelect_n && !writeStrobe_n, 2)) else $error("stray write");
    AST_REL_DONE: assert property (
        rxReleaseReq && rxReleaseDone && !regWrStb |=> !rxReleaseReq)
        else $error("release not cleared");
    AST_STEP: assert property (
        txBufWrite && !$past(regWrStb) && !$past(txEnqueueDone) |->
        txFramePointer == $past(txFramePointer) + stepW ||
        $stable(txFramePointer)) else $error("bad pointer step");
    AST_PTR_HOLD: assert property (
        !txBufWrite && !$past(regWrStb) && !$past(txEnqueueDone) |->
        $stable(txFramePointer)) else $error("pointer moved");
    AST_RELOAD: assert property (
        txEnqueueDone |=> txFramePointer == $past(txNextFree))
        else $error("pointer not reloaded");
    AST_ENQ_CLR: assert property (
        txEnqueueReq && txEnqueueDone && !regWrStb |=> !txEnqueueReq)
        else $error("enqueue not cleared");
    COV_WRITE: cover property (txBufWrite && txFramePointer != 11'h0);
    COV_DEQ: cover property (rxDequeue);
    COV_REL: cover property (rxReleaseReq && rxReleaseDone);
endmodule
bind hfq_access_ctrl hfq_access_ctrl_asserts #(
    .BYTE_CNT_W(BYTE_CNT_W),
    .FRAME_CNT_W(FRAME_CNT_W)
) chk (.*);
`default_nettype wire

// ===== tb/hfq_host_model.sv
// Purpose: host processor on the data strobe pins
// Assumes: the bench opens the access window first
// Notes: released size lines are driven to the inverse of the last size, not held
`timescale 1ns/10ps
`default_nettype none
module hfq_host_model (
    // clock
    input wire logic ref_clk,
    // host pins
    output logic chipSelect_n = 1'b1,
    output logic readStrobe_n = 1'b1,
    output logic writeStrobe_n = 1'b1,
    output logic cmdPin = 1'b1,
    output logic [1:0] hostAccessSize = 2'h3
);
    // strobe held five cycles to pass the synchroniser
    task automatic access(input logic isWrite, input logic [1:0] size);
        @(posedge ref_clk);
        chipSelect_n <= 1'b0;
        cmdPin <= 1'b0;
        hostAccessSize <= size;
        readStrobe_n <= isWrite;
        writeStrobe_n <= !isWrite;
        repeat (5) @(posedge ref_clk);
        {chipSelect_n, readStrobe_n, writeStrobe_n, cmdPin} <= 4'hf;
        hostAccessSize <= ~size;
        repeat (3) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// ===== tb/tb_host_frame_queue_access_control.sv
// Purpose: self-checking bench of the frame queue access control
// Assumes: host model drives the data strobes; clkEn dropped once
// Notes: expected values kept as integers beside the design
`timescale 1ns/10ps
`default_nettype none
`include "hfq_cfg.svh"
module tb_host_frame_queue_access_control;
    logic ref_clk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1;
    logic [8:0] regAddr = 9'h0;
    logic [15:0] regWrData = 16'h0, regRdData, d, rxByteCount = 16'h0;
    logic [15:0] rxByteThresholdValue = 16'h0;
    logic regWrStb = 1'b0, regRdStb = 1'b0, rxFrameReadDone = 1'b0;
    logic rxReleaseDone = 1'b0, txEnqueueDone = 1'b0;
    logic [7:0] rxFrameCount = 8'h0, rxFrameThresholdValue = 8'h0;
    logic [10:0] txNextFree = 11'h0, txFramePointer;
    logic chipSelect_n, readStrobe_n, writeStrobe_n, cmdPin, irq;
    logic rxThresholdIrq, rxDequeue, rxReleaseReq, rxBufRead;
    logic txEnqueueReq, txBufWrite;
    logic [1:0] hostAccessSize, bufAccessSize;
    logic [31:0] seed = 32'd45889, r;
    int n_fail = 0, compares = 0, cycles = 0, nWr = 0, nRd = 0, ptr = 16;
    hfq_access_ctrl dut (.*);
    hfq_host_model host (.*);
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cycles++;
        nWr += int'(txBufWrite);
        nRd += int'(rxBufRead);
        if (cycles == 3000)
            wrap_up(1);
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one register cycle; read data lands in d
    task automatic bus(input logic w, input logic [8:0] a,
        input logic [15:0] v);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= v;
        regWrStb <= w;
        regRdStb <= !w;
        @(posedge ref_clk);
        regWrStb <= 1'b0;
        regRdStb <= 1'b0;
        #1 d = regRdData;
    endtask
    task automatic wrap_up(input int extra);
        n_fail += extra;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        bus(1'b0, `HFQ_OFF_TXPTR, 16'h0);
        chk(d, 16'h0000);
        bus(1'b0, 9'h100, 16'h0);
        chk(d, 16'h0000);
        // a write while clkEn is low must not land
        @(posedge ref_clk);
        clkEn <= 1'b0;
        bus(1'b1, `HFQ_OFF_TXPTR, 16'h4123);
        @(posedge ref_clk);
        clkEn <= 1'b1;
        bus(1'b0, `HFQ_OFF_TXPTR, 16'h0);
        chk(d, 16'h0000);
        for (int i = 0; i < 8; i++)
        begin
            bus(1'b1, `HFQ_OFF_RXQCMD, (i < 4) ? 16'h0040 : 16'h0020);
            r = rnd();
            @(posedge ref_clk);
            rxByteCount <= {14'h0, r[1:0]};
            rxByteThresholdValue <= {14'h0, r[3:2]};
            rxFrameCount <= {6'h0, r[5:4]};
            rxFrameThresholdValue <= {6'h0, r[7:6]};
            repeat (3) @(posedge ref_clk);
            d = 16'((i < 4) ? r[1:0] > r[3:2] : r[5:4] > r[7:6]);
            #1 chk(16'(rxThresholdIrq), d);
        end
        for (int i = 0; i < 2; i++)
        begin
            bus(1'b1, `HFQ_OFF_RXQCMD, i ? 16'h0010 : 16'h0000);
            @(posedge ref_clk);
            rxFrameReadDone <= 1'b1;
            @(posedge ref_clk);
            rxFrameReadDone <= 1'b0;
            #1 chk(16'(rxDequeue), i[15:0]);
        end
        bus(1'b1, `HFQ_OFF_RXQCMD, 16'h0001);
        bus(1'b0, `HFQ_OFF_RXQCMD, 16'h0);
        chk(d & 16'h0001, 16'h0001);
        chk(16'(rxReleaseReq), 16'h0001);
        @(posedge ref_clk);
        rxReleaseDone <= 1'b1;
        @(posedge ref_clk);
        rxReleaseDone <= 1'b0;
        bus(1'b0, `HFQ_OFF_RXQCMD, 16'h0);
        chk(d & 16'h0001, 16'h0000);
        chk(16'(rxReleaseReq), 16'h0000);
        bus(1'b1, `HFQ_OFF_IRQMASK, 16'h0004);
        chk(16'(irq), 16'h0001);
        bus(1'b1, `HFQ_OFF_IRQSTAT, 16'h0004);
        chk(16'(irq), 16'h0000);
        bus(1'b1, `HFQ_OFF_TXPTR, 16'h4010);
        host.access(1'b1, 2'h1);
        chk(16'(txFramePointer), 16'h0010);
        bus(1'b1, `HFQ_OFF_RXQCMD, 16'h0008);
        bus(1'b0, `HFQ_OFF_TXPTR, 16'h0);
        chk(d, 16'h0000);
        for (int s = 0; s < 3; s++)
        begin
            host.access(1'b1, s[1:0]);
            ptr += 1 << s;
            chk(16'(txFramePointer), ptr[15:0]);
            // released size lines show the inverse, seen after sync
            chk(16'(bufAccessSize), {14'h0, ~s[1:0]});
        end
        host.access(1'b0, 2'h0);
        chk(nRd[15:0], 16'h0001);
        bus(1'b1, `HFQ_OFF_TXPTR, 16'h0020);
        bus(1'b1, `HFQ_OFF_RXQCMD, 16'h0000);
        bus(1'b0, `HFQ_OFF_TXPTR, 16'h0);
        chk(d, 16'h4000 | ptr[15:0]);
        bus(1'b1, `HFQ_OFF_TXPTR, 16'h0020);
        bus(1'b1, `HFQ_OFF_RXQCMD, 16'h0008);
        host.access(1'b1, 2'h2);
        chk(16'(txFramePointer), 16'h0020);
        chk(nWr[15:0], 16'h0004);
        bus(1'b1, `HFQ_OFF_RXQCMD, 16'h0000);
        r = rnd();
        bus(1'b1, `HFQ_OFF_TXCMD, 16'h0001);
        chk(16'(txEnqueueReq), 16'h0001);
        @(posedge ref_clk);
        txEnqueueDone <= 1'b1;
        txNextFree <= r[10:0];
        @(posedge ref_clk);
        txEnqueueDone <= 1'b0;
        txNextFree <= ~r[10:0];
        #1 chk(16'(txFramePointer), {5'h0, r[10:0]});
        chk(16'(txEnqueueReq), 16'h0000);
        // dequeue and enqueue events left sticky, release was cleared
        bus(1'b0, `HFQ_OFF_IRQSTAT, 16'h0);
        chk(d & 16'h000e, 16'h000a);
        // mid-run reset, held long enough for the checker's history
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        chk(16'(txFramePointer), 16'h0000);
        chk(16'(irq), 16'h0000);
        bus(1'b0, `HFQ_OFF_TXPTR, 16'h0);
        chk(d, 16'h0000);
        wrap_up(0);
    end
endmodule
`default_nettype wire
